// *** hw/rfm_monitor.sv ***
// Rail fault monitor: input current/power, pinstrap self check and
// the three-layer overvoltage scheme for one rail.
// Assumes i_srst is the supply power cycle and all inputs are
// synchronous digitised readings.
//
// Functional notes
// - Input overcurrent qualified 525 us; ignore, latch or hiccup; fault pin.
// - Input over-power above threshold for 525 us gives warning only.
// - Bad address or boot strap latches off until supply power cycle.
// - Enable cycle or clear clears latch; persisting condition re-trips at once.
// - Shutdowns drop rail good; unmasked status bits raise the alert.
// - Pre-bias OV at 3.7 V until init done; pulls all PWM low.
// - Pre-bias OV cannot be disabled; latched until power cycle.
// - Fixed OV starts when init completes, at most 20 ms.
// - Fixed OV compares positive sense against 0.6-3.7 V, converting or not.
// - Fixed OV tripped while off stays latched until power cycle.
// - Tracking OV fault checked only while converting.
// - OV warning keeps converting, sets status and alert.
// - OV fault applies response; non-ignore pulls PWM low immediately.
// - Fault offset from written limit, 32..448 mV in 32 mV steps.
// - Warning offset from written limit, 24..448 mV in 8 mV steps.
// - Trip levels: command plus offset minus droop; fault capped.
// - Command change keeps offsets; read limits add present command.
`default_nettype none

module rfm_monitor #(
	parameter int QUAL_COUNT    = rfm_pkg::QUAL_CYCLES,
	parameter int INIT_COUNT    = rfm_pkg::INIT_CYCLES,
	parameter int HICCUP_COUNT  = rfm_pkg::HICCUP_CYCLES
) (
	// Clock and reset (reset = supply power cycle)
	input  wire logic                          i_clock,
	input  wire logic                          i_srst,
	// Controller state
	input  wire logic                          i_conv_on,
	input  wire logic                          i_enable,
	input  wire logic                          i_init_done,
	input  wire logic                          i_clear_faults,
	// Pinstrap check result
	input  wire logic                          i_strap_check,
	input  wire logic                          i_addr_strap_ok,
	input  wire logic                          i_boot_strap_ok,
	// Measurements
	input  wire logic [rfm_pkg::AMP_W-1:0]     i_input_current,
	input  wire logic [rfm_pkg::WATT_W-1:0]    i_input_power,
	input  wire logic [rfm_pkg::MV_W-1:0]      i_sense_positive,
	input  wire logic [rfm_pkg::MV_W-1:0]      i_sense_diff,
	input  wire logic [rfm_pkg::MV_W-1:0]      i_droop_drop,
	// Configuration
	input  wire logic [rfm_pkg::AMP_W-1:0]     i_iin_oc_limit,
	input  wire logic [rfm_pkg::WATT_W-1:0]    i_pin_op_limit,
	input  wire logic [1:0]                    i_iin_oc_response,
	input  wire logic [1:0]                    i_ov_response,
	input  wire logic [4:0]                    i_fixed_overvoltage_threshold_cfg,
	input  wire logic [rfm_pkg::MV_W-1:0]      i_vout_command,
	input  wire logic [rfm_pkg::RECIP_W-1:0]   i_scale_recip,
	input  wire logic [rfm_pkg::MV_W-1:0]      i_ov_fault_limit,
	input  wire logic                          i_ov_fault_limit_wr,
	input  wire logic [rfm_pkg::MV_W-1:0]      i_ov_warn_limit,
	input  wire logic                          i_ov_warn_limit_wr,
	input  wire logic [rfm_pkg::ST_W-1:0]      i_alert_mask_setting,
	// Outputs
	output logic                               o_fault_output_n,
	output logic                               o_rail_good_output,
	output logic                               o_alert_n,
	output logic                               o_pwm_tristate,
	output logic                               o_pwm_force_low,
	output logic [rfm_pkg::ST_W-1:0]           o_status,
	output logic [rfm_pkg::MV_W-1:0]           o_ov_fault_limit_rd,
	output logic [rfm_pkg::MV_W-1:0]           o_ov_warn_limit_rd
);

	localparam int MW = rfm_pkg::MV_W;
	localparam int PW = MW + 1 + rfm_pkg::RECIP_W;
	localparam int IW = $clog2(INIT_COUNT + 1);
	localparam int HW = $clog2(HICCUP_COUNT + 1);

	// ************************************************************
	// Offset arithmetic
	// ************************************************************
	// Scale, round down to the step grid, clamp to the legal range
	function automatic logic [MW-1:0] calc_offset(
		input logic [MW-1:0]                  limit,
		input logic [MW-1:0]                  cmd,
		input logic [rfm_pkg::RECIP_W-1:0]    recip,
		input logic [MW-1:0]                  lo,
		input logic [MW-1:0]                  step
	);
		logic signed [MW:0] diff;
		logic signed [PW-1:0] prod;
		logic [MW-1:0] raw;
		logic [MW-1:0] snapped;
		diff = $signed({1'b0, limit}) - $signed({1'b0, cmd});
		prod = PW'(diff) * $signed({1'b0, recip});
		// Saturate large quotients so the narrowing cannot wrap
		raw = (prod < 0) ? '0 :
			((prod >>> rfm_pkg::RECIP_FRAC) > PW'(rfm_pkg::OFS_MAX_MV)) ?
			rfm_pkg::OFS_MAX_MV : MW'(prod >>> rfm_pkg::RECIP_FRAC);
		snapped = raw - (raw % step);
		if (snapped < lo)
			calc_offset = lo;
		else if (snapped > rfm_pkg::OFS_MAX_MV)
			calc_offset = rfm_pkg::OFS_MAX_MV;
		else
			calc_offset = snapped;
	endfunction

	// ************************************************************
	// Registers
	// ************************************************************
	logic [MW-1:0] ovf_offset;
	logic [MW-1:0] ovw_offset;
	logic [IW-1:0] init_count;
	logic          init_over;
	logic          enable_prev;
	logic          iin_oc_latch;
	logic          strap_latch;
	logic          prebias_latch;
	logic          ov_latch;
	logic          ov_catastrophic;
	logic          hiccup_wait;
	logic [HW-1:0] hiccup_count;
	logic [rfm_pkg::ST_W-1:0] status;

	// ************************************************************
	// Qualification of the input conditions
	// ************************************************************
	wire iin_oc_cond;
	wire pin_op_cond;
	wire iin_oc_qual;
	wire pin_op_qual;
	wire [rfm_pkg::AMP_W-1:0] iin_lim;
	wire [rfm_pkg::WATT_W-1:0] pin_lim;

	// Thresholds held inside the programmable range
	assign iin_lim = (i_iin_oc_limit < rfm_pkg::IIN_MIN_A) ?
		rfm_pkg::IIN_MIN_A : (i_iin_oc_limit > rfm_pkg::IIN_MAX_A) ?
		rfm_pkg::IIN_MAX_A : i_iin_oc_limit;
	assign pin_lim = (i_pin_op_limit < rfm_pkg::PIN_MIN_W) ?
		rfm_pkg::PIN_MIN_W :
		(i_pin_op_limit > rfm_pkg::PIN_MAX_W) ? rfm_pkg::PIN_MAX_W :
		i_pin_op_limit;
	assign iin_oc_cond = i_conv_on && (i_input_current > iin_lim);
	assign pin_op_cond = i_conv_on && (i_input_power > pin_lim);

	rfm_qualifier #(.COUNT(QUAL_COUNT)) u_iin_qual (
		.i_clock     (i_clock),
		.i_srst      (i_srst),
		.i_cond      (iin_oc_cond),
		.o_qualified (iin_oc_qual)
	);

	rfm_qualifier #(.COUNT(QUAL_COUNT)) u_pin_qual (
		.i_clock     (i_clock),
		.i_srst      (i_srst),
		.i_cond      (pin_op_cond),
		.o_qualified (pin_op_qual)
	);

	// ************************************************************
	// Overvoltage thresholds and conditions
	// ************************************************************
	wire [MW-1:0] fixed_mv;
	wire [MW:0]   ovw_sum;
	wire [MW:0]   ovf_sum;
	wire [MW:0]   ovw_trip;
	wire [MW:0]   ovf_track;
	wire [MW:0]   ovf_trip;
	wire          fixed_active;
	wire          prebias_window;
	wire          prebias_cond;
	wire          fixed_cond;
	wire          track_ovf_cond;
	wire          ovw_cond;

	// Codes past 3.7 V saturate at the top of the range
	assign fixed_mv = (i_fixed_overvoltage_threshold_cfg > 5'h1F) ?
		rfm_pkg::FIXED_MAX_MV : MW'(rfm_pkg::FIXED_BASE_MV +
		MW'(i_fixed_overvoltage_threshold_cfg) *
		rfm_pkg::FIXED_STEP_MV);
	assign ovw_sum = {1'b0, i_vout_command} + {1'b0, ovw_offset};
	assign ovf_sum = {1'b0, i_vout_command} + {1'b0, ovf_offset};
	// Droop larger than the sum floors the level at zero
	assign ovw_trip = (ovw_sum > {1'b0, i_droop_drop}) ?
		ovw_sum - {1'b0, i_droop_drop} : '0;
	assign ovf_track = (ovf_sum > {1'b0, i_droop_drop}) ?
		ovf_sum - {1'b0, i_droop_drop} : '0;
	assign ovf_trip = (ovf_track < {1'b0, fixed_mv}) ?
		ovf_track : {1'b0, fixed_mv};
	assign fixed_active = i_init_done || init_over;
	assign prebias_window = !fixed_active;
	assign prebias_cond = prebias_window &&
		(i_sense_positive > rfm_pkg::PREBIAS_OV_MV);
	assign fixed_cond = fixed_active && (i_sense_positive > fixed_mv);
	assign track_ovf_cond = i_conv_on &&
		({1'b0, i_sense_diff} > ovf_trip);
	assign ovw_cond = i_conv_on && ({1'b0, i_sense_diff} > ovw_trip);

	// ************************************************************
	// Clearing and response decode
	// ************************************************************
	wire enable_rise;
	wire clear_req;
	wire iin_trip;
	wire ov_trip;
	wire strap_bad;
	wire hiccup_done;
	wire shutdown;

	assign enable_rise = i_enable && !enable_prev;
	assign clear_req = i_clear_faults || enable_rise;
	assign iin_trip = iin_oc_qual &&
		(i_iin_oc_response != rfm_pkg::RFM_RESP_IGNORE);
	assign ov_trip = (fixed_cond || track_ovf_cond) &&
		(i_ov_response != rfm_pkg::RFM_RESP_IGNORE);
	assign strap_bad = i_strap_check &&
		!(i_addr_strap_ok && i_boot_strap_ok);
	assign hiccup_done = hiccup_wait &&
		(hiccup_count == HW'(HICCUP_COUNT - 1));
	assign shutdown = iin_oc_latch || strap_latch || prebias_latch ||
		ov_latch || ov_catastrophic;

	// ************************************************************
	// Init window timer
	// ************************************************************
	// Fixed OV starts on init done or on the 20 ms ceiling
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			init_count <= '0;
			init_over  <= 1'b0;
		end else if (init_count == IW'(INIT_COUNT - 1)) begin
			init_over <= 1'b1;
		end else begin
			init_count <= init_count + IW'(1);
		end
	end

	// ************************************************************
	// Stored offsets
	// ************************************************************
	// Only a limit write recomputes; command changes leave them alone
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			ovf_offset <= rfm_pkg::OFS_MAX_MV;
			ovw_offset <= rfm_pkg::OFS_MAX_MV;
		end else begin
			if (i_ov_fault_limit_wr)
				ovf_offset <= calc_offset(i_ov_fault_limit,
					i_vout_command, i_scale_recip,
					rfm_pkg::OVF_OFS_MIN_MV,
					rfm_pkg::OVF_OFS_STEP);
			if (i_ov_warn_limit_wr)
				ovw_offset <= calc_offset(i_ov_warn_limit,
					i_vout_command, i_scale_recip,
					rfm_pkg::OVW_OFS_MIN_MV,
					rfm_pkg::OVW_OFS_STEP);
		end
	end

	// ************************************************************
	// Fault latches
	// ************************************************************
	// Set terms come last so a live condition beats a clear
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			enable_prev     <= 1'b0;
			iin_oc_latch    <= 1'b0;
			strap_latch     <= 1'b0;
			prebias_latch   <= 1'b0;
			ov_latch        <= 1'b0;
			ov_catastrophic <= 1'b0;
		end else begin
			enable_prev <= i_enable;
			if (clear_req || hiccup_done) begin
				iin_oc_latch <= 1'b0;
				ov_latch     <= 1'b0;
			end
			if (iin_trip)
				iin_oc_latch <= 1'b1;
			if (ov_trip)
				ov_latch <= 1'b1;
			if (fixed_cond && !i_conv_on)
				ov_catastrophic <= 1'b1;
			if (prebias_cond)
				prebias_latch <= 1'b1;
			if (strap_bad)
				strap_latch <= 1'b1;
		end
	end

	// ************************************************************
	// Hiccup retry timer
	// ************************************************************
	// Waits out the retry time before the latch is released
	always_ff @(posedge i_clock) begin
		if (i_srst || hiccup_done || !shutdown) begin
			hiccup_wait  <= 1'b0;
			hiccup_count <= '0;
		end else if (hiccup_wait) begin
			hiccup_count <= hiccup_count + HW'(1);
		end else if ((iin_trip && i_iin_oc_response ==
			rfm_pkg::RFM_RESP_HICCUP) || (ov_trip &&
			i_ov_response == rfm_pkg::RFM_RESP_HICCUP)) begin
			hiccup_wait <= 1'b1;
		end
	end

	// ************************************************************
	// Sticky status bits
	// ************************************************************
	logic [rfm_pkg::ST_W-1:0] next_status;
	always_comb begin
		next_status = clear_req ? '0 : status;
		// Power-cycle-only faults survive a clear
		next_status[rfm_pkg::ST_STRAP] = strap_latch || strap_bad;
		next_status[rfm_pkg::ST_PREBIAS] = prebias_latch ||
			prebias_cond;
		if (iin_oc_qual)
			next_status[rfm_pkg::ST_IIN_OC] = 1'b1;
		if (pin_op_qual)
			next_status[rfm_pkg::ST_PIN_OP] = 1'b1;
		if (fixed_cond || ov_catastrophic)
			next_status[rfm_pkg::ST_FIXED_OV] = 1'b1;
		if (track_ovf_cond)
			next_status[rfm_pkg::ST_TRACK_OVF] = 1'b1;
		if (ovw_cond)
			next_status[rfm_pkg::ST_OVW] = 1'b1;
		next_status[rfm_pkg::ST_SUMMARY] =
			|next_status[rfm_pkg::ST_SUMMARY-1:0];
	end

	always_ff @(posedge i_clock) begin
		if (i_srst)
			status <= '0;
		else
			status <= next_status;
	end

	// ************************************************************
	// Output registers
	// ************************************************************
	// Warnings never touch the PWM or rail good
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_fault_output_n    <= 1'b1;
			o_rail_good_output  <= 1'b0;
			o_alert_n           <= 1'b1;
			o_pwm_tristate      <= 1'b0;
			o_pwm_force_low     <= 1'b0;
			o_status            <= '0;
			o_ov_fault_limit_rd <= '0;
			o_ov_warn_limit_rd  <= '0;
		end else begin
			o_fault_output_n <= !(iin_oc_latch || iin_trip);
			o_rail_good_output <= i_conv_on && !shutdown &&
				!iin_trip && !ov_trip && !strap_bad &&
				!prebias_cond;
			o_alert_n <= ~|(next_status &
				~i_alert_mask_setting);
			o_pwm_tristate <= iin_oc_latch || iin_trip ||
				strap_latch || strap_bad;
			o_pwm_force_low <= prebias_latch || prebias_cond ||
				ov_latch || ov_trip || ov_catastrophic;
			o_status <= next_status;
			o_ov_fault_limit_rd <= MW'(i_vout_command +
				ovf_offset);
			o_ov_warn_limit_rd <= MW'(i_vout_command +
				ovw_offset);
		end
	end

endmodule

`default_nettype wire

// *** hw/rfm_pkg.sv ***
// Constants shared by the rail fault monitor design.
// Assumes a 125 MHz core clock; all analog figures arrive as
// digitised unsigned numbers in mV, A or W.
`default_nettype none

package rfm_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int CLOCK_MHZ       = 125;
	localparam int QUAL_TIME_US    = 525;   // Input OC / OP qualify
	localparam int PREBIAS_MAX_US  = 350;   // Pre-bias OV latest start
	localparam int INIT_MAX_MS     = 20;    // Fixed OV latest start
	localparam int HICCUP_TIME_US  = 1000;  // Hiccup retry wait
	localparam int QUAL_CYCLES     = QUAL_TIME_US * CLOCK_MHZ;
	localparam int PREBIAS_CYCLES  = PREBIAS_MAX_US * CLOCK_MHZ;
	localparam int INIT_CYCLES     = INIT_MAX_MS * 1000 * CLOCK_MHZ;
	localparam int HICCUP_CYCLES   = HICCUP_TIME_US * CLOCK_MHZ;

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int MV_W    = 13;  // Voltages in mV
	localparam int AMP_W   = 8;   // Currents in A
	localparam int WATT_W  = 11;  // Power in W
	localparam int RECIP_W = 9;   // 1/scale_loop, Q1.8
	localparam int RECIP_FRAC = 8;

	// ************************************************************
	// Thresholds and offset ranges (mV)
	// ************************************************************
	localparam logic [MV_W-1:0] PREBIAS_OV_MV  = 13'hE74;  // 3700 mV
	localparam logic [MV_W-1:0] FIXED_BASE_MV  = 13'h258;  // 600 mV
	localparam logic [MV_W-1:0] FIXED_STEP_MV  = 13'h064;  // 100 mV
	localparam logic [MV_W-1:0] FIXED_MAX_MV   = 13'hE74;  // 3700 mV
	localparam logic [MV_W-1:0] OVF_OFS_MIN_MV = 13'h020;  // 32 mV
	localparam logic [MV_W-1:0] OVF_OFS_STEP   = 13'h020;  // 32 mV
	localparam logic [MV_W-1:0] OVW_OFS_MIN_MV = 13'h018;  // 24 mV
	localparam logic [MV_W-1:0] OVW_OFS_STEP   = 13'h008;  // 8 mV
	localparam logic [MV_W-1:0] OFS_MAX_MV     = 13'h1C0;  // 448 mV
	localparam logic [AMP_W-1:0]  IIN_MIN_A    = 8'h04;
	localparam logic [AMP_W-1:0]  IIN_MAX_A    = 8'h80;
	localparam logic [WATT_W-1:0] PIN_MIN_W    = 11'h008;
	localparam logic [WATT_W-1:0] PIN_MAX_W    = 11'h7FC;

	// ************************************************************
	// Fault responses
	// ************************************************************
	typedef enum logic [1:0] {
		RFM_RESP_IGNORE = 2'h0,
		RFM_RESP_LATCH  = 2'h1,
		RFM_RESP_HICCUP = 2'h2
	} rfm_resp_t;

	// ************************************************************
	// Status bit positions
	// ************************************************************
	localparam int ST_IIN_OC    = 0;
	localparam int ST_PIN_OP    = 1;
	localparam int ST_STRAP     = 2;
	localparam int ST_PREBIAS   = 3;
	localparam int ST_FIXED_OV  = 4;
	localparam int ST_TRACK_OVF = 5;
	localparam int ST_OVW       = 6;
	localparam int ST_SUMMARY   = 7;
	localparam int ST_W         = 8;

endpackage

`default_nettype wire

// *** hw/rfm_qualifier.sv ***
// Continuous-hold qualifier: output rises once the condition has held
// for COUNT cycles in a row. Assumes a synchronous condition input.
`default_nettype none

module rfm_qualifier #(
	parameter int COUNT = 65625
) (
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_srst,
	// Condition in, qualified level out
	input  wire logic i_cond,
	output logic      o_qualified
);

	localparam int CW = $clog2(COUNT + 1);
	localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

	logic [CW-1:0] count;

	// ************************************************************
	// Hold counter
	// ************************************************************
	// Any lapse drops the output and restarts the count
	always_ff @(posedge i_clock) begin
		if (i_srst || !i_cond) begin
			count       <= '0;
			o_qualified <= 1'b0;
		end else if (count == LAST) begin
			o_qualified <= 1'b1;
		end else begin
			count <= count + CW'(1);
		end
	end

endmodule

`default_nettype wire

// *** verification/rfm_host_model.sv ***
// Host model on the management side: sends clear-faults commands.
// Assumes the bench raises i_req for one cycle per wanted clear.
`default_nettype none

module rfm_host_model (
	// Clock
	input  wire logic i_clock,
	// Bench request in, command out
	input  wire logic i_req,
	output logic      o_clear
);
	timeunit 1ns;
	timeprecision 1ps;
	// Registered so the command changes just after an edge
	always_ff @(posedge i_clock) begin
		o_clear <= i_req;
	end
endmodule

`default_nettype wire

// *** verification/rfm_chk_monitor.sv ***
// Checker for the rail fault monitor, watching its top ports only.
// Assumes it is bound onto rfm_monitor with port names unchanged.
`default_nettype none

module rfm_chk_monitor #(
	parameter int QUAL_COUNT = 8
) (
	// Clock, reset and controls
	input wire logic        i_clock,
	input wire logic        i_srst,
	input wire logic        i_conv_on,
	input wire logic        i_ov_fault_limit_wr,
	input wire logic [1:0]  i_ov_response,
	// Readings and mask
	input wire logic [12:0] i_vout_command,
	input wire logic [12:0] i_sense_diff,
	input wire logic [7:0]  i_alert_mask_setting,
	// Design outputs
	input wire logic        o_fault_output_n,
	input wire logic        o_rail_good_output,
	input wire logic        o_alert_n,
	input wire logic        o_pwm_tristate,
	input wire logic        o_pwm_force_low,
	input wire logic [7:0]  o_status,
	input wire logic [12:0] o_ov_fault_limit_rd
);
	timeunit 1ns;
	timeprecision 1ps;
	int         run;
	logic [2:0] quiet;
	// Run length of conversion; read-back is stale just after a write
	always_ff @(posedge i_clock) begin
		run   <= (i_srst || !i_conv_on) ? 0 : run + 1;
		quiet <= (i_srst || i_ov_fault_limit_wr) ? 3'h0 :
			quiet + 3'(quiet != 3'h7);
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_srst);
	// ****
	// Assertions
	// ****
	a_alert_mask: assert property (
		!o_alert_n == |(o_status & ~$past(i_alert_mask_setting)))
		else $error("alert disagrees with status and mask");
	a_summary_or: assert property (
		o_status[7] == |o_status[6:0]) else $error("summary bit wrong");
	a_track_trip: assert property (
		i_conv_on && i_ov_response == 2'h1 && quiet > 3'h3 &&
		$stable(i_vout_command) && i_sense_diff > o_ov_fault_limit_rd
		|=> o_status[5] && o_pwm_force_low) else $error("missed OV trip");
	a_track_off: assert property (
		$rose(o_status[5]) |-> $past(i_conv_on)) else $error("OV while off");
	a_qual_hold: assert property (
		$rose(o_status[0]) || $rose(o_status[1]) |-> run >= QUAL_COUNT)
		else $error("qualified too early");
	a_strap_latch: assert property (
		o_status[2] |=> o_status[2] && o_pwm_tristate)
		else $error("strap latch lost");
	a_prebias_latch: assert property (
		o_status[3] |=> o_status[3] && o_pwm_force_low)
		else $error("pre-bias latch lost");
	a_rail_drop: assert property (
		o_pwm_force_low || o_pwm_tristate |-> !o_rail_good_output)
		else $error("rail good during shutdown");
	a_fault_pin: assert property (
		!o_fault_output_n |-> o_status[0]) else $error("stray fault pin");
	c_track: cover property ($rose(o_status[5]));
	c_qual: cover property ($rose(o_status[0]));
	c_strap: cover property ($rose(o_status[2]));
endmodule

bind rfm_monitor rfm_chk_monitor #(.QUAL_COUNT(QUAL_COUNT)) u_chk (.*);

`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the rail fault monitor.
// Assumes the checker binds itself and the host model sends clears.
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clock, i_srst, i_conv_on, i_enable, i_init_done;
	logic        i_clear_faults, i_strap_check, i_addr_strap_ok;
	logic        i_boot_strap_ok, i_ov_fault_limit_wr, i_ov_warn_limit_wr;
	logic        o_fault_output_n, o_rail_good_output, o_alert_n, host_req;
	logic        o_pwm_tristate, o_pwm_force_low;
	logic [1:0]  i_iin_oc_response, i_ov_response;
	logic [4:0]  i_fixed_overvoltage_threshold_cfg;
	logic [7:0]  i_input_current, i_iin_oc_limit, i_alert_mask_setting, o_status;
	logic [8:0]  i_scale_recip;
	logic [10:0] i_input_power, i_pin_op_limit;
	logic [12:0] i_sense_positive, i_sense_diff, i_droop_drop, i_vout_command;
	logic [12:0] i_ov_fault_limit, i_ov_warn_limit;
	logic [12:0] o_ov_fault_limit_rd, o_ov_warn_limit_rd;
	int          failures, tests_run;
	// Short counts keep qualification and hiccup waits brief
	rfm_monitor #(.QUAL_COUNT(8), .INIT_COUNT(20), .HICCUP_COUNT(16))
		u_dut (.*);
	rfm_host_model u_host (.i_clock(i_clock), .i_req(host_req),
		.o_clear(i_clear_faults));
	// 125 MHz clock
	initial begin
		i_clock = 1'h0;
		forever #4 i_clock = ~i_clock;
	end
	// ****
	// Shared tasks
	// ****
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clock);
	endtask
	task automatic ck(input logic [12:0] got, input logic [12:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask
	task automatic clr;
		host_req = 1'h1;
		cyc(1);
		host_req = 1'h0;
		cyc(1);
	endtask
	task automatic wr(input logic [12:0] f, input logic [12:0] w);
		{i_ov_fault_limit, i_ov_warn_limit} = {f, w};
		{i_ov_fault_limit_wr, i_ov_warn_limit_wr} = 2'h3;
		cyc(1);
		{i_ov_fault_limit_wr, i_ov_warn_limit_wr} = 2'h0;
		cyc(1);
	endtask
	task automatic rst;
		{i_conv_on, i_enable, i_init_done, i_strap_check, host_req} = '0;
		{i_ov_fault_limit_wr, i_ov_warn_limit_wr, i_input_current} = '0;
		{i_input_power, i_sense_positive, i_sense_diff, i_droop_drop} = '0;
		{i_ov_fault_limit, i_ov_warn_limit, i_alert_mask_setting} = '0;
		{i_addr_strap_ok, i_boot_strap_ok} = 2'h3;
		{i_iin_oc_limit, i_pin_op_limit} = {8'h14, 11'h064};
		{i_iin_oc_response, i_ov_response} = 4'h5;
		i_fixed_overvoltage_threshold_cfg = 5'h1F;
		{i_vout_command, i_scale_recip} = {13'h3E8, 9'h100};
		i_srst = 1'h1;
		cyc(10);
		i_srst = 1'h0;
		cyc(1);
	endtask
	task automatic results;
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_offset;
		rst;
		wr(13'h4E8, 13'h468); // 1256 and 1128 mV at 1000 mV
		ck(o_ov_fault_limit_rd, 13'h4E8);
		ck(o_ov_warn_limit_rd, 13'h468);
		i_vout_command = 13'h44C;
		cyc(1);
		ck(o_ov_fault_limit_rd, 13'h54C);
		ck(o_ov_warn_limit_rd, 13'h4CC);
		wr(13'h4B0, 13'h7D0); // Off-step fault, over-range warning
		ck(o_ov_fault_limit_rd, 13'h4AC);
		ck(o_ov_warn_limit_rd, 13'h60C);
	endtask
	task automatic t_track;
		rst;
		{i_init_done, i_conv_on} = 2'h3;
		wr(13'h5A8, 13'h468);
		i_sense_diff = 13'h4B0; // Above warning only
		cyc(1);
		ck(o_status[6], 1'h1);
		ck(o_pwm_force_low, 1'h0);
		ck(o_rail_good_output, 1'h1);
		{i_sense_diff, i_droop_drop} = {13'h5A0, 13'h00A};
		cyc(1);
		ck(o_pwm_force_low, 1'h1);
		ck(o_status[5], 1'h1);
		ck(o_rail_good_output, 1'h0);
		i_sense_diff = 13'h5B0; // Still over: clear must not stick
		clr;
		ck(o_pwm_force_low, 1'h1);
		i_sense_diff = '0;
		clr;
		ck(o_status, 8'h00);
		{i_conv_on, i_sense_diff} = {1'h0, 13'h7D0};
		cyc(2);
		ck(o_status[5], 1'h0);
	endtask
	task automatic t_fixed;
		rst;
		{i_init_done, i_fixed_overvoltage_threshold_cfg} = 6'h22;
		i_sense_positive = 13'h320; // Exactly 800 mV, not above
		cyc(2);
		ck(o_status[4], 1'h0);
		i_sense_positive = 13'h321;
		cyc(1);
		ck(o_pwm_force_low, 1'h1);
		i_sense_positive = '0;
		clr;
		ck(o_pwm_force_low, 1'h1);
	endtask
	task automatic t_prebias;
		rst;
		i_sense_positive = 13'hE75; // Just above 3700 mV
		cyc(1);
		ck(o_pwm_force_low, 1'h1);
		{i_sense_positive, i_init_done} = 14'h0001;
		clr;
		ck(o_status[3], 1'h1);
	endtask
	task automatic t_iin;
		for (int r = 0; r < 3; r++) begin
			rst;
			{i_iin_oc_response, i_alert_mask_setting} = {2'(r), 8'h83};
			{i_init_done, i_conv_on, i_input_power} = {2'h3, 11'h065};
			i_input_current = 8'h15;
			cyc(7);
			i_input_current = '0; // One-cycle lapse restarts the count
			cyc(1);
			i_input_current = 8'h15;
			cyc(8);
			ck(o_status[0], 1'h0);
			cyc(1);
			ck(o_fault_output_n, 13'(r == 0));
			ck(o_pwm_tristate, 13'(r != 0));
			ck(o_status[1], 1'h1);
			ck(o_alert_n, 1'h1);
		end
	endtask
	task automatic t_strap;
		rst;
		{i_strap_check, i_boot_strap_ok} = 2'h2;
		cyc(1);
		ck(o_pwm_tristate, 1'h1);
		{i_strap_check, i_boot_strap_ok, i_enable} = 3'h3;
		clr;
		ck(o_status[2], 1'h1);
	endtask
	// Main sequence
	initial begin
		{failures, tests_run} = '0;
		rst;
		ck(o_status, 8'h00);
		t_offset;
		t_track;
		t_fixed;
		t_prebias;
		t_iin;
		t_strap;
		results;
	end
	// Watchdog at about 17 times the expected run of about 176 cycles
	initial begin
		repeat (3000) @(posedge i_clock);
		failures++;
		results;
	end
endmodule

`default_nettype wire
